// file: core/c2rm_pkg.sv
package c2rm_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_MULT_LO    = 8'h71;
    localparam logic [7:0] IDX_MULT_HI    = 8'h72;
    localparam logic [7:0] IDX_CYC_UPPER  = 8'h74;
    localparam logic [7:0] IDX_LOW_LSB    = 8'h75;
    localparam logic [7:0] IDX_LOW_MSB    = 8'h76;
    localparam logic [7:0] IDX_HIGH_LSB   = 8'h77;
    localparam logic [7:0] IDX_HIGH_MSB   = 8'h78;
    localparam logic [7:0] IDX_WINDOW     = 8'h79;
    localparam logic [7:0] IDX_PRESCALE   = 8'h7A;
    localparam logic [7:0] IDX_STATUS     = 8'hF0;
    localparam logic [7:0] IDX_MEAS_LSB   = 8'hF1;
    localparam logic [7:0] IDX_MEAS_MSB   = 8'hF2;

    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [13:0] MULT_RESET    = 14'h0000;
    localparam logic [15:0] MEAS_RESET    = 16'h0000;
    localparam int          MULT_W        = 14;
    localparam int          PRESCALE_BIT  = 0;
    localparam int          PRESCALE_DIV  = 4;
    localparam logic [1:0]  PRESCALE_LAST = 2'h3;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;

    typedef struct packed {
        logic [13:0] mult;
        logic [7:0]  cycle_upper;
        logic [15:0] freq_lower;
        logic [15:0] freq_upper;
        logic [7:0]  window_count;
        logic        prescale_en;
    } c2rm_cfg_t;

    typedef struct packed {
        logic        freq_fail;
        logic        cycle_fail;
        logic        meas_valid;
        logic [15:0] last_meas;
    } c2rm_stat_t;

endpackage

// file: core/c2rm_edge.sv
`timescale 1ns/10ps
module c2rm_edge
(
    input  wire logic MCLK_I,
    input  wire logic RST_I,
    input  wire logic ce_i,
    input  wire logic ref_i,
    input  wire logic prescale_en_i,
    output logic      edge_o,
    output logic      tick_o
);
    logic [2:0] sync;
    logic       level;
    logic [1:0] div;
    logic       next_level;
    logic [1:0] next_div;
    logic       next_edge;
    logic       next_tick;

    always_comb
    begin
        next_level = level;
        next_div   = div;
        next_edge  = 1'b0;
        next_tick  = 1'b0;
        // a new level is accepted once the second and third stages agree
        if (sync[1] == sync[2])
        begin
            next_level = sync[2];
        end
        if (next_level && !level)
        begin
            next_edge = 1'b1;
            if (prescale_en_i)
            begin
                // one tick per four reference edges
                next_div  = div + 2'h1;
                next_tick = (div == c2rm_pkg::PRESCALE_LAST);
            end
            else
            begin
                next_div  = 2'h0;
                next_tick = 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sync   <= 3'h0;
            level  <= 1'b0;
            div    <= 2'h0;
            edge_o <= 1'b0;
            tick_o <= 1'b0;
        end
        else if (ce_i)
        begin
            sync   <= {sync[1:0], ref_i};
            level  <= next_level;
            div    <= next_div;
            edge_o <= next_edge;
            tick_o <= next_tick;
        end
    end
endmodule

// file: core/c2rm_top.sv
`timescale 1ns/10ps
module c2rm_top
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              MCLK_I,
    input  wire logic              RST_I,
    input  wire logic              CE_I,
    input  wire logic              REF_I,
    input  wire logic              PSEL_I,
    input  wire logic              PENABLE_I,
    input  wire logic              PWRITE_I,
    input  wire logic [ADDR_W-1:0] PADDR_I,
    input  wire logic [31:0]       PWDATA_I,
    output logic      [31:0]       PRDATA_O,
    output logic                   PREADY_O,
    output logic                   PSLVERR_O,
    output logic                   FREQ_FAIL_O,
    output logic                   CYCLE_FAIL_O
);
    c2rm_pkg::c2rm_cfg_t  cfg;
    c2rm_pkg::c2rm_cfg_t  next_cfg;
    c2rm_pkg::c2rm_stat_t stat;
    c2rm_pkg::c2rm_stat_t next_stat;
    logic [31:0]          next_prdata;
    logic                 next_pready;
    logic                 next_pslverr;
    logic [7:0]           idx;
    logic                 aligned;
    logic                 hit;
    logic [7:0]           rd_byte;
    logic                 wr_en;
    logic                 ref_edge;
    logic                 ref_tick;
    logic [15:0]          period_cnt;
    logic [15:0]          meas_cnt;
    logic [7:0]           win_cnt;
    logic [15:0]          next_period_cnt;
    logic [15:0]          next_meas_cnt;
    logic [7:0]           next_win_cnt;

    c2rm_edge u_edge
    (
        .MCLK_I        (MCLK_I),
        .RST_I         (RST_I),
        .ce_i          (CE_I),
        .ref_i         (REF_I),
        .prescale_en_i (cfg.prescale_en),
        .edge_o        (ref_edge),
        .tick_o        (ref_tick)
    );

    // address decode: word-aligned, index above bit 1
    always_comb
    begin
        idx     = PADDR_I[9:2];
        aligned = (PADDR_I[1:0] == 2'h0) && (PADDR_I[ADDR_W-1:10] == '0);
        hit     = 1'b1;
        rd_byte = c2rm_pkg::REG_RESET;
        unique case (idx)
            c2rm_pkg::IDX_MULT_LO:   rd_byte = cfg.mult[7:0];
            c2rm_pkg::IDX_MULT_HI:   rd_byte = {2'h0, cfg.mult[13:8]};
            c2rm_pkg::IDX_CYC_UPPER: rd_byte = cfg.cycle_upper;
            c2rm_pkg::IDX_LOW_LSB:   rd_byte = cfg.freq_lower[7:0];
            c2rm_pkg::IDX_LOW_MSB:   rd_byte = cfg.freq_lower[15:8];
            c2rm_pkg::IDX_HIGH_LSB:  rd_byte = cfg.freq_upper[7:0];
            c2rm_pkg::IDX_HIGH_MSB:  rd_byte = cfg.freq_upper[15:8];
            c2rm_pkg::IDX_WINDOW:    rd_byte = cfg.window_count;
            c2rm_pkg::IDX_PRESCALE:  rd_byte = {7'h00, cfg.prescale_en};
            c2rm_pkg::IDX_STATUS:    rd_byte = {5'h00, stat.meas_valid, stat.cycle_fail,
                                                stat.freq_fail};
            c2rm_pkg::IDX_MEAS_LSB:  rd_byte = stat.last_meas[7:0];
            c2rm_pkg::IDX_MEAS_MSB:  rd_byte = stat.last_meas[15:8];
            default:                 hit = 1'b0;
        endcase
        hit = hit && aligned;
    end

    assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I && !PSLVERR_O;

    // apb slave: answer prepared in setup, pready high for the single access cycle
    always_comb
    begin
        next_cfg     = cfg;
        next_prdata  = PRDATA_O;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (PSEL_I && !PENABLE_I)
        begin
            next_pready  = 1'b1;
            next_pslverr = !hit;
            next_prdata  = (hit && !PWRITE_I) ? {24'h000000, rd_byte} : 32'h00000000;
        end
        if (wr_en)
        begin
            unique case (idx)
                c2rm_pkg::IDX_MULT_LO:   next_cfg.mult[7:0] = PWDATA_I[7:0];
                c2rm_pkg::IDX_MULT_HI:   next_cfg.mult[13:8] = PWDATA_I[5:0];
                c2rm_pkg::IDX_CYC_UPPER: next_cfg.cycle_upper = PWDATA_I[7:0];
                c2rm_pkg::IDX_LOW_LSB:   next_cfg.freq_lower[7:0] = PWDATA_I[7:0];
                c2rm_pkg::IDX_LOW_MSB:   next_cfg.freq_lower[15:8] = PWDATA_I[7:0];
                c2rm_pkg::IDX_HIGH_LSB:  next_cfg.freq_upper[7:0] = PWDATA_I[7:0];
                c2rm_pkg::IDX_HIGH_MSB:  next_cfg.freq_upper[15:8] = PWDATA_I[7:0];
                c2rm_pkg::IDX_WINDOW:    next_cfg.window_count = PWDATA_I[7:0];
                c2rm_pkg::IDX_PRESCALE:
                    next_cfg.prescale_en = PWDATA_I[c2rm_pkg::PRESCALE_BIT];
                default:                 next_cfg = cfg;
            endcase
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cfg       <= '{c2rm_pkg::MULT_RESET, c2rm_pkg::REG_RESET, c2rm_pkg::MEAS_RESET,
                           c2rm_pkg::MEAS_RESET, c2rm_pkg::REG_RESET, 1'b0};
            PRDATA_O  <= 32'h00000000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end
        else if (CE_I)
        begin
            cfg       <= next_cfg;
            PRDATA_O  <= next_prdata;
            PREADY_O  <= next_pready;
            PSLVERR_O <= next_pslverr;
        end
    end

    // monitor: per-cycle period check and windowed frequency check
    always_comb
    begin
        next_stat       = stat;
        next_period_cnt = period_cnt;
        next_meas_cnt   = meas_cnt;
        next_win_cnt    = win_cnt;
        if (period_cnt != c2rm_pkg::CNT_MAX)
        begin
            next_period_cnt = period_cnt + 16'h0001;
        end
        if (meas_cnt != c2rm_pkg::CNT_MAX)
        begin
            next_meas_cnt = meas_cnt + 16'h0001;
        end
        // per-cycle check: period in system clocks above the upper limit fails,
        // also flagged while waiting so a lost reference is seen early
        if (ref_edge)
        begin
            next_stat.cycle_fail = (period_cnt > {8'h00, cfg.cycle_upper});
            next_period_cnt      = 16'h0000;
        end
        else if (period_cnt > {8'h00, cfg.cycle_upper})
        begin
            next_stat.cycle_fail = 1'b1;
        end
        if (ref_tick)
        begin
            if (win_cnt >= cfg.window_count)
            begin
                // window closes after window_count + 1 counted cycles; a count lowered
                // below the running position closes on the next tick instead of wrapping 256 ticks
                next_win_cnt         = 8'h00;
                next_meas_cnt        = 16'h0000;
                next_stat.last_meas  = meas_cnt;
                next_stat.meas_valid = 1'b1;
                next_stat.freq_fail  = (meas_cnt < cfg.freq_lower)
                                     || (meas_cnt > cfg.freq_upper);
            end
            else
            begin
                next_win_cnt = win_cnt + 8'h01;
            end
        end
    end

    always_ff @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            stat         <= '{1'b0, 1'b0, 1'b0, c2rm_pkg::MEAS_RESET};
            period_cnt   <= c2rm_pkg::MEAS_RESET;
            meas_cnt     <= c2rm_pkg::MEAS_RESET;
            win_cnt      <= c2rm_pkg::REG_RESET;
            FREQ_FAIL_O  <= 1'b0;
            CYCLE_FAIL_O <= 1'b0;
        end
        else if (CE_I)
        begin
            stat         <= next_stat;
            period_cnt   <= next_period_cnt;
            meas_cnt     <= next_meas_cnt;
            win_cnt      <= next_win_cnt;
            FREQ_FAIL_O  <= next_stat.freq_fail;
            CYCLE_FAIL_O <= next_stat.cycle_fail;
        end
    end
endmodule

// file: verif/c2rm_top_asserts.sv
`timescale 1ns/10ps
module c2rm_chk
#(
    parameter int ADDR_W = 12
)
(
    input wire logic              MCLK_I,
    input wire logic              RST_I,
    input wire logic              CE_I,
    input wire logic              PSEL_I,
    input wire logic              PENABLE_I,
    input wire logic              PWRITE_I,
    input wire logic [ADDR_W-1:0] PADDR_I,
    input wire logic [31:0]       PRDATA_O,
    input wire logic              PREADY_O,
    input wire logic              PSLVERR_O,
    input wire logic              FREQ_FAIL_O,
    input wire logic              CYCLE_FAIL_O
);
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    logic setup;
    assign setup = PSEL_I && !PENABLE_I && CE_I;
    property p_ready; setup |=> PREADY_O; endproperty
    property p_one; PREADY_O && CE_I |=> !PREADY_O; endproperty
    property p_err; PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0; endproperty
    property p_width; PREADY_O |-> PRDATA_O[31:8] == 24'h0; endproperty
    property p_unmap; setup && PADDR_I[11:10] != 2'h0 |=> PSLVERR_O; endproperty
    property p_presc;
        setup && !PWRITE_I && PADDR_I == {2'h0, c2rm_pkg::IDX_PRESCALE, 2'h0}
            |=> PRDATA_O[7:1] == 7'h00;
    endproperty
    property p_hold; !$rose(PREADY_O) |-> $stable(PRDATA_O); endproperty
    property p_freeze;
        !CE_I |=> $stable(FREQ_FAIL_O) && $stable(CYCLE_FAIL_O) && $stable(PREADY_O)
                  && $stable(PRDATA_O);
    endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_one: assert property (p_one) else $error("ready longer than one cycle");
    a_err: assert property (p_err) else $error("error without ready or zero");
    a_width: assert property (p_width) else $error("upper read bits set");
    a_unmap: assert property (p_unmap) else $error("unmapped not refused");
    a_presc: assert property (p_presc) else $error("prescale reserved bits");
    a_hold: assert property (p_hold) else $error("read data changed");
    a_freeze: assert property (p_freeze) else $error("state moved while off");
    c_freq: cover property ($rose(FREQ_FAIL_O));
    c_cyc: cover property ($rose(CYCLE_FAIL_O));
    c_err: cover property (PSLVERR_O);
endmodule

// file: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int LIMIT = 6000;
    logic        mclk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        ref_in = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        freq_fail;
    logic        cycle_fail;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [7:0]  val;
    int          mismatches = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          ref_cnt = 0;

    always #25 mclk = ~mclk;

    c2rm_top #(.ADDR_W(12)) i_c2rm_top (.MCLK_I(mclk), .RST_I(rst), .CE_I(ce),
        .REF_I(ref_in), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .FREQ_FAIL_O(freq_fail), .CYCLE_FAIL_O(cycle_fail));

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // reference of eight clocks per period
    always @(posedge mclk)
    begin
        ref_cnt <= ref_cnt + 1;
        ref_in <= ref_cnt[2];
        cyc <= cyc + 1;
        if (cyc == LIMIT)
        begin
            mismatches++;
            end_of_test();
        end
    end

    always @(posedge mclk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            note = exp_q.pop_front();
            chk("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
            if (!pwrite)
                chk("prdata", prdata, note[31:0]);
        end
    end

    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic e);
        exp_q.push_back({e, d});
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [11:0] ba(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction

    task automatic wr(input logic [7:0] idx, input logic [7:0] v);
        acc(1'b1, ba(idx), {24'h0, v}, 1'b0);
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] v);
        acc(1'b0, ba(idx), {24'h0, v}, 1'b0);
    endtask

    task automatic flags(input logic f, input logic c);
        chk("freq_fail", {31'h0, freq_fail}, {31'h0, f});
        chk("cycle_fail", {31'h0, cycle_fail}, {31'h0, c});
    endtask

    initial
    begin
        void'($urandom(51));
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(c2rm_pkg::IDX_MULT_LO, 8'h00);
        rd(c2rm_pkg::IDX_MULT_HI, 8'h00);
        for (int i = 0; i < 7; i++)
            rd(c2rm_pkg::IDX_CYC_UPPER + 8'(i), 8'h00);
        $display("test reset values done");
        for (int i = 0; i < 6; i++)
        begin
            val = 8'($urandom);
            wr(c2rm_pkg::IDX_CYC_UPPER + 8'(i), val);
            rd(c2rm_pkg::IDX_CYC_UPPER + 8'(i), val);
        end
        val = 8'($urandom);
        wr(c2rm_pkg::IDX_PRESCALE, val);
        rd(c2rm_pkg::IDX_PRESCALE, {7'h00, val[0]});
        acc(1'b1, 12'h400, 32'h0000_00FF, 1'b1);
        acc(1'b0, 12'h400, 32'h0, 1'b1);
        $display("test register access done");
        wr(c2rm_pkg::IDX_WINDOW, 8'h03);
        wr(c2rm_pkg::IDX_PRESCALE, 8'h00);
        wr(c2rm_pkg::IDX_CYC_UPPER, 8'h0C);
        wr(c2rm_pkg::IDX_LOW_LSB, 8'h10);
        wr(c2rm_pkg::IDX_LOW_MSB, 8'h00);
        wr(c2rm_pkg::IDX_HIGH_LSB, 8'h1E);
        wr(c2rm_pkg::IDX_HIGH_MSB, 8'h00);
        repeat (200) @(posedge mclk);
        rd(c2rm_pkg::IDX_MEAS_LSB, 8'h1F);
        rd(c2rm_pkg::IDX_MEAS_MSB, 8'h00);
        flags(1'b1, 1'b0);
        rd(c2rm_pkg::IDX_STATUS, 8'h05);
        wr(c2rm_pkg::IDX_HIGH_MSB, 8'h01);
        repeat (100) @(posedge mclk);
        flags(1'b0, 1'b0);
        wr(c2rm_pkg::IDX_LOW_MSB, 8'h01);
        repeat (100) @(posedge mclk);
        flags(1'b1, 1'b0);
        wr(c2rm_pkg::IDX_LOW_MSB, 8'h00);
        wr(c2rm_pkg::IDX_PRESCALE, 8'h01);
        repeat (600) @(posedge mclk);
        rd(c2rm_pkg::IDX_MEAS_LSB, 8'h7F);
        flags(1'b0, 1'b0);
        $display("test frequency window done");
        ce <= 1'b0;
        repeat (20) @(posedge mclk);
        ce <= 1'b1;
        wr(c2rm_pkg::IDX_CYC_UPPER, 8'h04);
        repeat (50) @(posedge mclk);
        flags(1'b0, 1'b1);
        $display("test cycle limit done");
        end_of_test();
    end
endmodule

bind c2rm_top c2rm_chk #(.ADDR_W(ADDR_W)) i_c2rm_chk (.MCLK_I, .RST_I, .CE_I, .PSEL_I,
    .PENABLE_I, .PWRITE_I, .PADDR_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .FREQ_FAIL_O,
    .CYCLE_FAIL_O);
